// ===== rtl/sk_parity.sv
// stack datapath constants package, and the address-and-data parity unit
// assumes one processor clock; the parity unit is purely combinational
package sk_pkg;
  // build choice: small stack keeps a 9-bit pointer, large a 12-bit one
  localparam int          SP_W          = 12;
  localparam logic [11:0] SP_MASK_SMALL = 12'h1ff;
  localparam logic [11:0] SP_MASK_LARGE = 12'hfff;
  localparam int          RAM_DEPTH     = 1024;
  localparam int          RAM_AW        = 10;
  localparam int          DW            = 16;
  localparam int          SA_W          = 24;
  localparam int          ROM_PAR_W     = 7;
  localparam logic [7:0]  NOCHECK_PAGE  = 8'hff;

  // microcode control word layout
  localparam int UW          = 21;
  localparam int F_SP_OP     = 0;
  localparam int F_RAM_ASEL  = 2;
  localparam int F_RAM_WR    = 4;
  localparam int F_RAM_RD    = 5;
  localparam int F_EXT_LD    = 6;
  localparam int F_PIPE_OP   = 7;
  localparam int F_TOS_LD    = 9;
  localparam int F_TOS_SRC   = 10;
  localparam int F_TOS_GP_LD = 11;
  localparam int F_TOS_MATE  = 12;
  localparam int F_S1_SEL    = 13;
  localparam int F_S1_EN     = 15;
  localparam int F_S2_SEL    = 16;
  localparam int F_S2_EN     = 17;
  localparam int F_ST_WR     = 18;
  localparam int F_ST_RD     = 19;
  localparam int F_PAR_CLR   = 20;

  typedef enum logic [1:0] {
    SK_SP_HOLD = 2'b00,
    SK_SP_PUSH = 2'b01,
    SK_SP_POP  = 2'b10,
    SK_SP_LOAD = 2'b11
  } sk_sp_op_e;

  typedef enum logic [1:0] {
    SK_RA_SP     = 2'b00,
    SK_RA_PIPE   = 2'b01,
    SK_RA_RESULT = 2'b10,
    SK_RA_STORE  = 2'b11
  } sk_ram_asel_e;

  typedef enum logic [1:0] {
    SK_PIPE_HOLD  = 2'b00,
    SK_PIPE_RAM   = 2'b01,
    SK_PIPE_STORE = 2'b10,
    SK_PIPE_SHL   = 2'b11
  } sk_pipe_op_e;

  typedef enum logic [1:0] {
    SK_S1_TOS  = 2'b00,
    SK_S1_PIPE = 2'b01,
    SK_S1_EXT  = 2'b10,
    SK_S1_SP   = 2'b11
  } sk_s1_sel_e;
endpackage

`timescale 1ns/1ps
module sk_parity
  import sk_pkg::*;
(
  // word under protection
  input  wire logic [SA_W-1:0] addr,
  input  wire logic [DW-1:0]   data,
  // parity that came with the word
  input  wire logic            par_in,
  // results
  output logic                 par_gen,
  output logic                 mismatch
);
  // one parity bit covers address and data together
  always_comb begin
    par_gen  = ^{addr, data};
    mismatch = par_gen ^ par_in;
  end
endmodule

// ===== rtl/sk_datapath.sv
// stack and register datapath of a microcoded processor
// assumes sequencer and arithmetic unit share sys_clk; store and mate pins are foreign
//
// Behaviour
// - stack pointer counts up/down under microcode, 9 or 12 bits by build.
// - four microcode-selected RAM address sources, stack pointer among them.
// - RAM stack holds 1K words of 16 bits plus one parity bit.
// - extension register loads from upper byte of combined RAM/store path.
// - extension register drives upper byte of 24-bit store address, loadable alongside low.
// - 16-bit pipe register is one source operand for arithmetic.
// - pipe register loads from RAM stack or data store under microcode.
// - pipe register shifts left holding the multiplicand during multiply.
// - top-of-stack register is fast stack top and sole write data source.
// - top-of-stack register carries data exchanged with mate processor.
// - top-of-stack register loads as general register under separate bit.
// - first source bus selects top, pipe, extension or stack pointer, tristate.
// - second source bus selects top or pipe, tristate.
// - top-of-stack input mux picks combined path or result bus.
// - block drives and receives a 16-bit bidirectional data store bus.
// - block takes 16-bit results from result bus into top-of-stack.
// - microcode fields decode into local register and mux controls.
// - one parity bit generated over seven microcode bits received.
// - parity generated and checked over address and data, RAM and store.
// - store parity check suppressed in the no-check page.
`timescale 1ns/1ps
module sk_datapath
  import sk_pkg::*;
#(
  parameter bit STACK_LARGE = 1'b0
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  // microcode from the sequencer
  input  wire logic [UW-1:0]        ucode,
  input  wire logic [ROM_PAR_W-1:0] ucode_par_bits,
  // arithmetic unit side
  input  wire logic [DW-1:0]        result_bus,
  input  wire logic [DW-1:0]        store_address_low,
  // data store bus pins
  input  wire logic [DW-1:0]        data_store_in,
  input  wire logic                 data_store_par_in,
  output logic [DW-1:0]             data_store_out,
  output logic                      data_store_oe,
  output logic                      data_store_par_out,
  output logic                      data_store_wr,
  output logic                      data_store_rd,
  output logic [7:0]                upper_byte,
  // source buses
  output logic [DW-1:0]             first_source_bus,
  output logic                      first_source_bus_oe,
  output logic [DW-1:0]             second_source_bus,
  output logic                      second_source_bus_oe,
  // mate processor exchange
  input  wire logic [DW-1:0]        mate_data_in,
  output logic [DW-1:0]             mate_data_out,
  // maintenance
  output logic                      rom_parity,
  output logic                      parity_error
);

  typedef struct packed {
    logic [SP_W-1:0]                 sp;
    logic [7:0]                      ext;
    logic [DW-1:0]                   pipe;
    logic [DW-1:0]                   top_of_stack_reg;
    logic [RAM_DEPTH-1:0][DW:0]      ram;
    logic [DW-1:0]                   ds_m;
    logic [DW-1:0]                   ds_s;
    logic                            dsp_m;
    logic                            dsp_s;
    logic [DW-1:0]                   mate_m;
    logic [DW-1:0]                   mate_s;
    logic [DW-1:0]                   s1_q;
    logic                            s1_oe;
    logic [DW-1:0]                   s2_q;
    logic                            s2_oe;
    logic [DW-1:0]                   st_d;
    logic                            st_oe;
    logic                            st_par;
    logic                            st_wr;
    logic                            st_rd;
    logic                            rom_par;
    logic                            par_err;
  } sk_state_s;

  sk_state_s       r;
  sk_state_s       next_r;

  // decoded microcode fields
  sk_sp_op_e       sp_op;
  sk_ram_asel_e    ram_asel;
  sk_pipe_op_e     pipe_op;
  sk_s1_sel_e      s1_sel;
  logic            ram_wr;
  logic            ram_rd;
  logic            ext_ld;
  logic            tos_ld;
  logic            tos_src;
  logic            tos_gp_ld;
  logic            tos_mate;
  logic            s2_sel;
  logic            s1_en;
  logic            s2_en;
  logic            st_wr;
  logic            st_rd;
  logic            par_clr;

  logic [SP_W-1:0] sp_mask;
  logic [RAM_AW-1:0] ram_addr;
  logic [DW:0]     ram_q;
  logic [DW-1:0]   comb_path;
  logic [SA_W-1:0] ram_addr_x;
  logic [SA_W-1:0] st_addr;
  logic            ram_par_bad;
  logic            st_par_bad;
  logic            st_par_out;
  logic            st_used;
  logic            ram_chk;
  logic            st_chk;
  logic [DW-1:0]   tos_in;

  always_comb begin
    sp_op     = sk_sp_op_e'(ucode[F_SP_OP +: 2]);
    ram_asel  = sk_ram_asel_e'(ucode[F_RAM_ASEL +: 2]);
    pipe_op   = sk_pipe_op_e'(ucode[F_PIPE_OP +: 2]);
    s1_sel    = sk_s1_sel_e'(ucode[F_S1_SEL +: 2]);
    ram_wr    = ucode[F_RAM_WR];
    ram_rd    = ucode[F_RAM_RD];
    ext_ld    = ucode[F_EXT_LD];
    tos_ld    = ucode[F_TOS_LD];
    tos_src   = ucode[F_TOS_SRC];
    tos_gp_ld = ucode[F_TOS_GP_LD];
    tos_mate  = ucode[F_TOS_MATE];
    s2_sel    = ucode[F_S2_SEL];
    s1_en     = ucode[F_S1_EN];
    s2_en     = ucode[F_S2_EN];
    st_wr     = ucode[F_ST_WR];
    st_rd     = ucode[F_ST_RD];
    par_clr   = ucode[F_PAR_CLR];
  end

  // ram address sources
  always_comb begin
    sp_mask = STACK_LARGE ? SP_MASK_LARGE : SP_MASK_SMALL;
    unique case (ram_asel)
      SK_RA_SP:     ram_addr = r.sp[RAM_AW-1:0];
      SK_RA_PIPE:   ram_addr = r.pipe[RAM_AW-1:0];
      SK_RA_RESULT: ram_addr = result_bus[RAM_AW-1:0];
      SK_RA_STORE:  ram_addr = store_address_low[RAM_AW-1:0];
    endcase
    ram_q      = r.ram[ram_addr];
    ram_addr_x = {{(SA_W-RAM_AW){1'b0}}, ram_addr};
    st_addr    = {r.ext, store_address_low};
    // combined path: ram word when reading ram, else received store data
    comb_path  = ram_rd ? ram_q[DW-1:0] : r.ds_s;
    tos_in     = tos_src ? result_bus : comb_path;
  end

  // ram parity covers address and data
  sk_parity u_ram_par (
    .addr     (ram_addr_x),
    .data     (ram_rd ? ram_q[DW-1:0] : r.top_of_stack_reg),
    .par_in   (ram_q[DW]),
    .par_gen  (),
    .mismatch (ram_par_bad)
  );

  // store parity for received data
  sk_parity u_st_par (
    .addr     (st_addr),
    .data     (r.ds_s),
    .par_in   (r.dsp_s),
    .par_gen  (),
    .mismatch (st_par_bad)
  );

  always_comb begin
    // parity sent with store write data
    st_par_out = ^{st_addr, r.top_of_stack_reg};
    st_used    = !ram_rd && ((pipe_op == SK_PIPE_STORE) ||
                 ((tos_ld || tos_gp_ld) && !tos_src) || ext_ld);
    ram_chk    = ram_rd && ram_par_bad;
    st_chk     = st_used && st_par_bad && (r.ext != NOCHECK_PAGE);
  end

  always_comb begin
    next_r = r;

    // pin inputs pass two flops first
    next_r.ds_m   = data_store_in;
    next_r.ds_s   = r.ds_m;
    next_r.dsp_m  = data_store_par_in;
    next_r.dsp_s  = r.dsp_m;
    next_r.mate_m = mate_data_in;
    next_r.mate_s = r.mate_m;

    unique case (sp_op)
      SK_SP_HOLD: next_r.sp = r.sp;
      SK_SP_PUSH: next_r.sp = (r.sp + 12'h001) & sp_mask;
      SK_SP_POP:  next_r.sp = (r.sp - 12'h001) & sp_mask;
      SK_SP_LOAD: next_r.sp = result_bus[SP_W-1:0] & sp_mask;
    endcase

    if (ram_wr) begin
      // write parity always over top of stack, even with a read in the same word
      next_r.ram[ram_addr] = {^{ram_addr_x, r.top_of_stack_reg}, r.top_of_stack_reg};
    end

    if (ext_ld) begin
      next_r.ext = comb_path[DW-1:8];
    end

    unique case (pipe_op)
      SK_PIPE_HOLD:  next_r.pipe = r.pipe;
      SK_PIPE_RAM:   next_r.pipe = ram_q[DW-1:0];
      SK_PIPE_STORE: next_r.pipe = r.ds_s;
      SK_PIPE_SHL:   next_r.pipe = {r.pipe[DW-2:0], 1'b0};
    endcase

    // mate exchange wins over other loads
    if (tos_mate) begin
      next_r.top_of_stack_reg = r.mate_s;
    end else if (tos_ld || tos_gp_ld) begin
      next_r.top_of_stack_reg = tos_in;
    end

    unique case (s1_sel)
      SK_S1_TOS:  next_r.s1_q = r.top_of_stack_reg;
      SK_S1_PIPE: next_r.s1_q = r.pipe;
      SK_S1_EXT:  next_r.s1_q = {8'h00, r.ext};
      SK_S1_SP:   next_r.s1_q = {{(DW-SP_W){1'b0}}, r.sp};
    endcase
    next_r.s1_oe = s1_en;
    next_r.s2_q  = s2_sel ? r.pipe : r.top_of_stack_reg;
    next_r.s2_oe = s2_en;

    next_r.st_d   = r.top_of_stack_reg;
    next_r.st_oe  = st_wr;
    next_r.st_par = st_par_out;
    next_r.st_wr  = st_wr;
    next_r.st_rd  = st_rd;

    next_r.rom_par = ^ucode_par_bits;

    // a new mismatch beats a clear in the same cycle
    if (ram_chk || st_chk) begin
      next_r.par_err = 1'b1;
    end else if (par_clr) begin
      next_r.par_err = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    data_store_out       = r.st_d;
    data_store_oe        = r.st_oe;
    data_store_par_out   = r.st_par;
    data_store_wr        = r.st_wr;
    data_store_rd        = r.st_rd;
    upper_byte           = r.ext;
    first_source_bus     = r.s1_q;
    first_source_bus_oe  = r.s1_oe;
    second_source_bus    = r.s2_q;
    second_source_bus_oe = r.s2_oe;
    mate_data_out        = r.top_of_stack_reg;
    rom_parity           = r.rom_par;
    parity_error         = r.par_err;
  end

endmodule

// ===== testbench/sk_datapath_assertions.sv
// concurrent checks on the stack datapath ports
// assumes binding onto sk_datapath, one clock domain
`timescale 1ns/1ps
module sk_datapath_assertions
  import sk_pkg::*;
#(
  parameter bit STACK_LARGE = 1'b0
) (
  input wire logic                 sys_clk,
  input wire logic                 rstn,
  input wire logic [UW-1:0]        ucode,
  input wire logic [ROM_PAR_W-1:0] ucode_par_bits,
  input wire logic [DW-1:0]        result_bus,
  input wire logic [DW-1:0]        store_address_low,
  input wire logic [DW-1:0]        data_store_in,
  input wire logic                 data_store_par_in,
  input wire logic [DW-1:0]        data_store_out,
  input wire logic                 data_store_oe,
  input wire logic                 data_store_par_out,
  input wire logic                 data_store_wr,
  input wire logic                 data_store_rd,
  input wire logic [7:0]           upper_byte,
  input wire logic [DW-1:0]        first_source_bus,
  input wire logic                 first_source_bus_oe,
  input wire logic [DW-1:0]        second_source_bus,
  input wire logic                 second_source_bus_oe,
  input wire logic [DW-1:0]        mate_data_in,
  input wire logic [DW-1:0]        mate_data_out,
  input wire logic                 rom_parity,
  input wire logic                 parity_error
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_store_wr: assert property (ucode[F_ST_WR] |=> data_store_wr && data_store_oe)
    else $error("store write strobe missing");
  a_store_data: assert property (ucode[F_ST_WR] |=> data_store_out == $past(mate_data_out))
    else $error("store write data not top of stack");
  a_rom_par: assert property (1'b1 |=> rom_parity == ^$past(ucode_par_bits))
    else $error("rom parity wrong");
  a_s1_sp: assert property (ucode[F_S1_EN] && ucode[F_S1_SEL+:2] == SK_S1_SP |=>
    first_source_bus_oe && (first_source_bus >> (STACK_LARGE ? 12 : 9)) == 16'h0)
    else $error("pointer wider than build");
  a_s1_ext: assert property (ucode[F_S1_EN] && ucode[F_S1_SEL+:2] == SK_S1_EXT |=>
    first_source_bus == {8'h00, $past(upper_byte)})
    else $error("first bus extension value wrong");
  a_s2_oe: assert property (1'b1 |=> second_source_bus_oe == $past(ucode[F_S2_EN]))
    else $error("second bus enable wrong");
  a_err_hold: assert property (parity_error && !ucode[F_PAR_CLR] |=> parity_error)
    else $error("error flag dropped without clear");
  a_err_cause: assert property ($rose(parity_error) |-> $past(ucode[F_RAM_RD]) || $past(ucode[F_EXT_LD]) ||
    $past(ucode[F_PIPE_OP+:2]) == SK_PIPE_STORE ||
    (($past(ucode[F_TOS_LD]) || $past(ucode[F_TOS_GP_LD])) && !$past(ucode[F_TOS_SRC])))
    else $error("error flag without access");
  a_no_check: assert property (upper_byte == 8'hff && !ucode[F_RAM_RD] && !parity_error |=>
    !parity_error)
    else $error("error flagged in unchecked page");
  c_ram_rd: cover property (ucode[F_RAM_RD]);
  c_err: cover property ($rose(parity_error));
  c_sp: cover property (ucode[F_S1_EN] && ucode[F_S1_SEL+:2] == SK_S1_SP);
endmodule

bind sk_datapath sk_datapath_assertions #(.STACK_LARGE(STACK_LARGE)) sk_datapath_assertions_inst (.*);

// ===== testbench/sk_store_model.sv
// data store partner: keeps written words, answers reads
// assumes low 8 address bits select the word; bus toggles when released
`timescale 1ns/1ps
module sk_store_model (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        data_store_wr,
  input  wire logic        data_store_rd,
  input  wire logic [15:0] data_store_out,
  input  wire logic        data_store_par_out,
  input  wire logic [15:0] store_address_low,
  output logic [15:0]      data_store_in,
  output logic             data_store_par_in
);
  logic [16:0] mem [256];
  logic [2:0]  hold;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hold <= 3'h0;
      {data_store_par_in, data_store_in} <= 17'h0;
    end else begin
      if (data_store_wr)
        mem[store_address_low[7:0]] <= {data_store_par_out, data_store_out};
      if (data_store_rd) begin
        hold <= 3'h6;
        {data_store_par_in, data_store_in} <= mem[store_address_low[7:0]];
      end else if (hold != 3'h0)
        hold <= hold - 3'h1;
      else
        {data_store_par_in, data_store_in} <= ~{data_store_par_in, data_store_in};
    end
  end
endmodule

// ===== testbench/sk_datapath_test.sv
// self-checking bench for the stack datapath, small stack build
// assumes the store model answers reads on the store pins
`timescale 1ns/1ps
module sk_datapath_test
  import sk_pkg::*;
;
  localparam int TR = 3 << F_TOS_LD;
  localparam int S2T = 1 << F_S2_EN;
  localparam int S2P = 3 << F_S2_SEL;
  localparam int S1SP = 7 << F_S1_SEL;
  localparam int S1X = 6 << F_S1_SEL;
  localparam int PR = (1 << F_PIPE_OP) | (1 << F_RAM_RD);
  localparam int PS = 2 << F_PIPE_OP;
  localparam int SR = 1 << F_ST_RD;
  logic                 sys_clk = 1'b0;
  logic                 rstn = 1'b0;
  logic [UW-1:0]        ucode = '0;
  logic [ROM_PAR_W-1:0] ucode_par_bits = '0;
  logic [DW-1:0]        result_bus = '0, store_address_low = '0, mate_data_in = '0;
  logic [DW-1:0]        data_store_in, data_store_out, first_source_bus, second_source_bus, mate_data_out;
  logic                 data_store_par_in, data_store_oe, data_store_par_out, data_store_wr, data_store_rd;
  logic                 first_source_bus_oe, second_source_bus_oe, rom_parity, parity_error;
  logic [7:0]           upper_byte;
  int                   fails = 0, num_checks = 0;
  logic [15:0]          rv [4] = '{16'h0001, 16'h8000, 16'hffff, 16'h5a5a};
  logic [6:0]           rp [4] = '{7'h00, 7'h01, 7'h7f, 7'h33};
  logic                 ep [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  sk_datapath #(.STACK_LARGE(1'b0)) sk_datapath_inst (.*);
  sk_store_model sk_store_model_inst (.*);

  always #5 sys_clk = ~sys_clk;

  task automatic step(input int u);
    @(negedge sys_clk);
    ucode = UW'(u);
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // write value through top of stack to the store
  task automatic wrst(input logic [15:0] v);
    result_bus = v;
    step(TR);
    step(1 << F_ST_WR);
    step(0);
  endtask
  // read request, then consume after the pin synchroniser
  task automatic rdst(input int u);
    step(SR);
    repeat (3) step(0);
    step(u);
    step(0);
  endtask

  initial begin
    #100000;
    fails++;
    results();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    #1 chk(16'({first_source_bus_oe, data_store_oe, parity_error}), 16'h0);
    @(negedge sys_clk) rstn = 1'b1;
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      result_bus = rv[i];
      ucode_par_bits = rp[i];
      step(TR);
      step(S2T);
      step(0);
      chk(second_source_bus, rv[i]);
      chk(mate_data_out, rv[i]);
      chk(16'(rom_parity), 16'(ep[i]));
    end
    $display("test table done");
    step(2);
    step(S1SP | 1);
    step(0);
    chk(first_source_bus, 16'h01ff);
    for (int i = 0; i < 3; i++) begin
      result_bus = 16'h1110 + 16'(i);
      step(TR);
      step(1 | (1 << F_RAM_WR));
    end
    step(S1SP | 2);
    step(PR);
    chk(first_source_bus, 16'h0003);
    step(S2P);
    step(0);
    chk(second_source_bus, 16'h1112);
    chk(16'(parity_error), 16'h0);
    $display("test stack done");
    mate_data_in = 16'h4321;
    result_bus = 16'h0000;
    step((1 << F_TOS_GP_LD) | (1 << F_RAM_RD) | (2 << F_RAM_ASEL));
    step(3 << F_PIPE_OP);
    chk(mate_data_out, 16'h1110);
    step((1 << F_S1_SEL) | (1 << F_S1_EN));
    result_bus = 16'h0e5a;
    step((1 << F_TOS_MATE) | TR | 3);
    chk(first_source_bus, 16'h2224);
    step(S1SP);
    chk(mate_data_out, 16'h4321);
    step(0);
    chk(first_source_bus, 16'h005a);
    $display("test mux done");
    store_address_low = 16'h0012;
    wrst(16'habcd);
    chk(data_store_out, 16'habcd);
    chk(16'({data_store_oe, data_store_wr}), 16'h3);
    rdst(PS | (1 << F_EXT_LD));
    step(S2P | S1X);
    step(0);
    chk(second_source_bus, 16'habcd);
    chk(first_source_bus, 16'h00ab);
    chk(16'(upper_byte), 16'h00ab);
    chk(16'(parity_error), 16'h0);
    rdst(PS);
    chk(16'(parity_error), 16'h1);
    repeat (2) step(0);
    chk(16'(parity_error), 16'h1);
    step(1 << F_PAR_CLR);
    step(0);
    chk(16'(parity_error), 16'h0);
    $display("test parity done");
    wrst(16'hff00);
    rdst(1 << F_EXT_LD);
    chk(16'(upper_byte), 16'h00ff);
    rdst(PS);
    chk(16'(parity_error), 16'h0);
    $display("test page done");
    @(negedge sys_clk) rstn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk(16'({upper_byte, data_store_oe, parity_error}), 16'h0);
    @(negedge sys_clk) rstn = 1'b1;
    step(S1SP);
    step(0);
    chk(first_source_bus, 16'h0000);
    $display("test reset again done");
    results();
  end
endmodule
